// >>> hdl/bps_pkg.sv
// Shared constants, state codes and carrier structs of the beacon period slot manager
package bps_pkg;

	// Clock and slot timing
	localparam int CLK_NS   = 10;
	localparam int SLOT_NS  = 1000;
	localparam int BCN_NS   = 800;
	localparam int GUARD_NS = 20;
	localparam int SLOT_CYC = SLOT_NS / CLK_NS;
	localparam int BCN_CYC  = BCN_NS / CLK_NS;
	localparam int GRD2_CYC = (2 * GUARD_NS) / CLK_NS;

	// Widths
	localparam int CW       = 7;
	localparam int SW       = 8;
	localparam int IW       = 5;
	localparam int NSLOT    = 32;
	localparam int LOST_WIN = 4;

	typedef logic [CW-1:0]    bps_cyc_t;
	typedef logic [SW-1:0]    bps_slot_t;
	typedef logic [NSLOT-1:0] bps_vec_t;
	typedef logic [3:0]       bps_sf_t;

	localparam bps_cyc_t  CYC_LAST = bps_cyc_t'(SLOT_CYC - 1);
	localparam bps_cyc_t  BCN_LAST = bps_cyc_t'(BCN_CYC - 1);
	localparam bps_cyc_t  GRD_LO   = bps_cyc_t'(GRD2_CYC);
	localparam bps_cyc_t  GRD_HI   = bps_cyc_t'(SLOT_CYC - GRD2_CYC);

	// Beacon period geometry, in slots
	localparam bps_slot_t MAX_BP    = 8'h20;
	localparam bps_slot_t SIG_SLOTS = 8'h02;
	localparam bps_slot_t BP_EXT    = 8'h04;
	localparam bps_slot_t SF_LAST   = 8'hFF;
	localparam bps_slot_t SLOT_ONE  = 8'h01;

	// Superframe counts
	localparam bps_sf_t   LOST_AGE  = 4'h4;
	localparam bps_sf_t   DISC_LAT  = 4'h8;
	localparam bps_sf_t   NBR_DET   = 4'hF;
	localparam logic [1:0] SCAN_MIN   = 2'h1;
	localparam logic [1:0] SCAN_NOBCN = 2'h2;
	localparam logic [1:0] SCAN_EXTRA = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_BEACON, ST_SUSP} bps_state_t;

	typedef struct packed {
		logic      dev_b;
		logic      start_scan;
		logic      beam_busy;
		logic      peer_found;
		logic      peer_trains;
		logic      train_done;
		logic      power_save;
		logic      disc_chan;
		logic      disc_busy;
		logic      skip_now;
		logic      abs_grant;
		logic      move_req;
		bps_slot_t move_slot;
	} bps_cfg_t;

	typedef struct packed {
		logic      hdr;
		logic      fcs_ok;
		logic      aligned;
		logic      type_b;
		logic      preempt;
		logic      sig_slot;
		logic      busy_other;
		logic      occ_vld;
		logic      occ_bcst;
		bps_slot_t slot_num;
		bps_slot_t bp_len;
		bps_slot_t occ_slot;
	} bps_rx_t;

	typedef struct packed {
		logic      bp_start;
		logic      tx_start;
		logic      tx_on;
		logic      active;
		logic      bcn_ready;
		logic      dual;
		logic      created;
		logic      withheld;
		logic      relocate;
		logic      absence_req;
		logic      disc_late;
		logic      quiet;
		logic      sf_ex_en;
		logic      suspended;
		logic      lock;
		bps_slot_t my_slot;
		bps_slot_t bp_len;
		bps_slot_t slot_cnt;
	} bps_out_t;

endpackage

// >>> hdl/bps_slot_hist.sv
// Per-slot occupancy and monitoring history over the recent superframe window
`timescale 1ns/10ps
`default_nettype none
module bps_slot_hist
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Observations of the running superframe
	input  wire logic              sf_end,
	input  wire bps_pkg::bps_vec_t occ_set,
	input  wire bps_pkg::bps_vec_t mon_set,
	// Window results and running superframe marks
	output var  bps_pkg::bps_vec_t unavail,
	output var  bps_pkg::bps_vec_t mon,
	output var  bps_pkg::bps_vec_t cur_occ,
	output var  bps_pkg::bps_vec_t cur_mon
);
	import bps_pkg::*;

	typedef struct packed {
		bps_vec_t                         cur_occ;
		bps_vec_t                         cur_mon;
		logic [LOST_WIN-1:0][NSLOT-1:0] occ_h;
		logic [LOST_WIN-1:0][NSLOT-1:0] mon_h;
	} bps_hist_st_t;

	bps_hist_st_t                     s_r;
	bps_hist_st_t                     s_nxt;
	logic [NSLOT-1:0][LOST_WIN-1:0] occ_col;
	logic [NSLOT-1:0][LOST_WIN-1:0] mon_col;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.cur_occ = s_r.cur_occ | occ_set;
		s_nxt.cur_mon = s_r.cur_mon | mon_set;
		if (sf_end)
		begin
			s_nxt.occ_h   = {s_r.occ_h[LOST_WIN-2:0], s_r.cur_occ | occ_set};
			s_nxt.mon_h   = {s_r.mon_h[LOST_WIN-2:0], s_r.cur_mon | mon_set};
			s_nxt.cur_occ = '0;
			s_nxt.cur_mon = '0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Any superframe of the window marks the slot
	for (genvar i = 0; i < NSLOT; i++)
	begin : g_slot
		for (genvar w = 0; w < LOST_WIN; w++)
		begin : g_win
			assign occ_col[i][w] = s_r.occ_h[w][i];
			assign mon_col[i][w] = s_r.mon_h[w][i];
		end
		assign unavail[i] = |occ_col[i];
		assign mon[i]     = |mon_col[i];
	end

	assign cur_occ = s_r.cur_occ;
	assign cur_mon = s_r.cur_mon;
endmodule
`default_nettype wire

// >>> hdl/bps_mgr.sv
// Beacon period slot manager: scan, initial slot choice, beacon timing and BP length
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1 - Type A Ready beacons wait for a found peer and finished antenna training.
// R2 - Type A scans one superframe before beaconing, two when no beacon arrives.
// R3 - Type A headers without a good checksum add one scan superframe.
// R4 - Type A hearing no headers creates a period, first slot after signalling.
// R5 - Type A hearing beacons joins just after the highest unavailable slot.
// R6 - Type A already beaconing requests relocation on misaligned beacons.
// R7 - Type A already beaconing adds a second beacon by the joining rule.
// R8 - Stay silent inside neighbours' announced periods heard in the recent window.
// R9 - Never move the beacon below the highest unavailable slot.
// R10 - Type A requests an absence period soon after it starts beaconing.
// R11 - Type B Ready beacons wait for a peer; same scan lengths apply.
// R12 - Type B on an idle channel creates a period and sends a dual-beacon.
// R13 - Type B hearing only Type B joins by extension, else withholds.
// R14 - Type B skipping hears other traffic and freezes its slots.
// R15 - No exchanges on a busy discovery channel; preemption suspends then restarts.
// R16 - Period has numbered slots, the first few for signalling, bounded length.
// R17 - Beacon starts exactly at slot start and ends within its airtime limit.
// R18 - Beacon is sent only when the chosen slot lies inside the period.
// R19 - A slot is unavailable when seen or reported occupied in the window.
// R20 - A slot is monitored on aligned, near-boundary or addressed reports.
// R21 - Announced length covers own, monitored and signalled slots.
// R22 - Announced length adds at most the extension, capped, none when power saving.
// R23 - Slot counter restarts each period; per-slot history kept over the window.
module bps_mgr
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Controls from the upper MAC
	input  wire bps_pkg::bps_cfg_t cfg,
	// Receive events, one cycle each
	input  wire bps_pkg::bps_rx_t  rx,
	// Status and transmit timing
	output var  bps_pkg::bps_out_t st_out
);
	import bps_pkg::*;

	typedef struct packed {
		bps_state_t st;
		bps_cyc_t   cyc;
		bps_cyc_t   txc;
		logic [1:0] scan_sf;
		logic       hdr_seen;
		logic       ok_seen;
		logic       misalign;
		logic       foreign;
		bps_slot_t  nb_len;
		bps_sf_t    nb_age;
		bps_slot_t  sig_cur;
		bps_sf_t    lat;
		bps_sf_t    susp;
		bps_out_t   o;
	} bps_mgr_st_t;

	bps_mgr_st_t s_r;
	bps_mgr_st_t s_nxt;
	logic        sf_end;
	logic        in_bp;
	logic [1:0]  sfn;
	logic [1:0]  need;
	bps_slot_t   join_s;
	bps_slot_t   pick;
	bps_slot_t   hi_unav;
	bps_slot_t   req;
	bps_slot_t   ext;
	logic        fresh;
	bps_vec_t    occ_set;
	bps_vec_t    mon_set;
	bps_vec_t    unavail;
	bps_vec_t    mon;
	bps_vec_t    cur_occ;
	bps_vec_t    cur_mon;

	// Slot just past the highest marked one, zero when none
	function automatic bps_slot_t hi_next(input bps_vec_t v);
		hi_next = '0;
		for (int i = 0; i < NSLOT; i++)
			if (v[i])
				hi_next = bps_slot_t'(i + 1);
	endfunction

	function automatic bps_slot_t smax(input bps_slot_t a, input bps_slot_t b);
		smax = (a > b) ? a : b;
	endfunction

	bps_slot_hist bps_slot_hist_inst
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.sf_end  (sf_end),
		.occ_set (occ_set),
		.mon_set (mon_set),
		.unavail (unavail),
		.mon     (mon),
		.cur_occ (cur_occ),
		.cur_mon (cur_mon)
	);

	// Observations of the current slot
	always_comb
	begin
		sf_end  = (s_r.cyc == CYC_LAST) && (s_r.o.slot_cnt == SF_LAST); // R23
		in_bp   = s_r.o.slot_cnt < MAX_BP;
		occ_set = '0;
		mon_set = '0;
		if (in_bp && rx.hdr)
			occ_set[s_r.o.slot_cnt[IW-1:0]] = 1'b1; // R19
		if (rx.occ_vld && (rx.occ_slot < MAX_BP))
		begin
			occ_set[rx.occ_slot[IW-1:0]] = 1'b1; // R19
			if (!rx.occ_bcst)
				mon_set[rx.occ_slot[IW-1:0]] = 1'b1; // R20
		end
		if (in_bp && rx.fcs_ok && rx.aligned)
			mon_set[s_r.o.slot_cnt[IW-1:0]] = 1'b1; // R20
		if (in_bp && rx.hdr && !rx.fcs_ok && ((s_r.cyc < GRD_LO) || (s_r.cyc >= GRD_HI)))
			mon_set[s_r.o.slot_cnt[IW-1:0]] = 1'b1; // R20
	end

	// Slot choice and announced length
	always_comb
	begin
		hi_unav = hi_next(unavail | cur_occ);
		join_s  = (hi_unav < SIG_SLOTS) ? SIG_SLOTS : hi_unav; // R5 R7 R13
		fresh   = !s_r.hdr_seen && (cfg.dev_b || !cfg.beam_busy);
		pick    = fresh ? SIG_SLOTS : join_s; // R4 R12
		sfn     = s_r.scan_sf + 2'h1;
		need    = s_r.ok_seen ? SCAN_MIN : (s_r.hdr_seen ? SCAN_EXTRA : SCAN_NOBCN); // R2 R3 R11 R12
		req     = smax(hi_next(mon | cur_mon), s_r.sig_cur); // R21
		if (s_r.o.active)
			req = smax(req, s_r.o.my_slot + SLOT_ONE); // R21
		if (req > MAX_BP)
			req = MAX_BP;
		ext = req + BP_EXT; // R22
		if (ext > MAX_BP)
			ext = MAX_BP; // R22
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.o.bp_start = 1'b0;
		s_nxt.o.tx_start = 1'b0;
		s_nxt.o.relocate = 1'b0;

		// Slot clock restarted at each period start
		if (s_r.cyc == CYC_LAST)
		begin
			s_nxt.cyc        = '0;
			s_nxt.o.slot_cnt = (s_r.o.slot_cnt == SF_LAST) ? '0 : s_r.o.slot_cnt + SLOT_ONE; // R16 R23
			s_nxt.o.bp_start = (s_nxt.o.slot_cnt == '0);
		end
		else
			s_nxt.cyc = s_r.cyc + 7'h01;

		s_nxt.o.sf_ex_en = !(cfg.disc_chan && cfg.disc_busy); // R15

		// Neighbour period to keep quiet in
		if (rx.fcs_ok && rx.aligned && !rx.sig_slot
			&& ((rx.bp_len >= s_r.nb_len) || (s_r.nb_age >= LOST_AGE)))
		begin
			s_nxt.nb_len = (rx.bp_len > MAX_BP) ? MAX_BP : rx.bp_len; // R8
			s_nxt.nb_age = '0;
		end
		else if (sf_end && (s_r.nb_age < LOST_AGE))
			s_nxt.nb_age = s_r.nb_age + 4'h1; // R8

		// Slots named by signalling slot beacons
		if (rx.fcs_ok && rx.sig_slot)
			s_nxt.sig_cur = smax(s_r.sig_cur, rx.slot_num + SLOT_ONE); // R21
		if (sf_end)
		begin
			s_nxt.o.bp_len = cfg.power_save ? req : ext; // R21 R22
			s_nxt.sig_cur  = '0;
		end

		unique case (s_r.st)
			ST_IDLE:
			begin
				if (cfg.start_scan && s_r.o.bp_start)
				begin
					s_nxt.st       = ST_SCAN;
					s_nxt.scan_sf  = '0;
					s_nxt.hdr_seen = 1'b0;
					s_nxt.ok_seen  = 1'b0;
					s_nxt.misalign = 1'b0;
					s_nxt.foreign  = 1'b0;
				end
			end
			ST_SCAN:
			begin
				if (rx.hdr)
					s_nxt.hdr_seen = 1'b1;
				if (rx.fcs_ok)
				begin
					s_nxt.ok_seen = 1'b1;
					if (!rx.aligned)
						s_nxt.misalign = 1'b1;
					if (rx.type_b != cfg.dev_b)
						s_nxt.foreign = 1'b1;
				end
				if (rx.preempt && cfg.disc_chan)
				begin
					s_nxt.st   = ST_SUSP; // R15
					s_nxt.susp = '0;
				end
				else if (sf_end)
				begin
					if (sfn >= need) // R2 R3 R11
					begin
						s_nxt.o.withheld = 1'b0;
						s_nxt.o.created  = 1'b0;
						if (!cfg.dev_b && cfg.beam_busy && s_r.misalign)
						begin
							s_nxt.o.relocate = 1'b1; // R6
							s_nxt.st         = ST_IDLE;
						end
						else if (cfg.dev_b && s_r.hdr_seen && (s_r.foreign || !s_r.ok_seen))
						begin
							s_nxt.o.withheld = 1'b1; // R13
							s_nxt.st         = ST_IDLE;
						end
						else if (pick < MAX_BP) // R18
						begin
							s_nxt.st            = ST_BEACON;
							s_nxt.o.my_slot     = pick; // R4 R5 R7 R12 R13
							s_nxt.o.created     = fresh;
							s_nxt.o.dual        = cfg.dev_b; // R12 R13
							s_nxt.o.absence_req = !cfg.dev_b; // R10
							s_nxt.o.disc_late   = 1'b0;
							s_nxt.o.lock        = 1'b0;
							s_nxt.lat           = '0;
						end
						else
						begin
							s_nxt.o.withheld = 1'b1; // R18
							s_nxt.st         = ST_IDLE;
						end
					end
					else
						s_nxt.scan_sf = sfn;
				end
			end
			ST_BEACON:
			begin
				if (rx.preempt && cfg.disc_chan)
				begin
					s_nxt.st   = ST_SUSP; // R15
					s_nxt.susp = '0;
				end
				if (cfg.dev_b && cfg.skip_now && rx.busy_other)
					s_nxt.o.lock = 1'b1; // R14
				if (cfg.move_req && !s_r.o.lock && (cfg.move_slot >= hi_unav)
					&& (cfg.move_slot >= SIG_SLOTS) && (cfg.move_slot < MAX_BP))
					s_nxt.o.my_slot = cfg.move_slot; // R9 R14
				if (cfg.abs_grant)
					s_nxt.o.absence_req = 1'b0; // R10
				if (sf_end && (s_r.lat < DISC_LAT))
					s_nxt.lat = s_r.lat + 4'h1;
				if (s_r.o.absence_req && (s_r.lat >= DISC_LAT))
					s_nxt.o.disc_late = 1'b1; // R10
			end
			ST_SUSP:
			begin
				if (sf_end)
				begin
					if (s_r.susp >= NBR_DET)
						s_nxt.st = ST_IDLE; // R15
					else
						s_nxt.susp = s_r.susp + 4'h1; // R15
				end
			end
		endcase

		if (s_nxt.st != ST_BEACON)
		begin
			s_nxt.o.absence_req = 1'b0;
			s_nxt.o.dual        = 1'b0;
		end
		s_nxt.o.active    = (s_nxt.st == ST_BEACON);
		s_nxt.o.suspended = (s_nxt.st == ST_SUSP);
		s_nxt.o.bcn_ready = s_nxt.o.active && cfg.peer_found
			&& (cfg.dev_b || !cfg.peer_trains || cfg.train_done); // R1 R11

		// Beacon airtime window
		if (s_r.o.tx_on)
		begin
			if (s_r.txc == BCN_LAST)
				s_nxt.o.tx_on = 1'b0; // R17
			else
				s_nxt.txc = s_r.txc + 7'h01;
		end
		if (s_nxt.o.active && s_nxt.o.sf_ex_en && !cfg.skip_now && (s_nxt.cyc == '0)
			&& (s_nxt.o.slot_cnt == s_nxt.o.my_slot))
		begin
			s_nxt.o.tx_start = 1'b1; // R17
			s_nxt.o.tx_on    = 1'b1;
			s_nxt.txc        = '0;
		end

		s_nxt.o.quiet = (s_nxt.nb_age < LOST_AGE) && (s_nxt.o.slot_cnt < s_nxt.nb_len)
			&& !(s_nxt.o.active && (s_nxt.o.slot_cnt == s_nxt.o.my_slot)); // R8
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign st_out = s_r.o;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_tx_at_edge: assert property (st_out.tx_start |-> s_r.cyc == '0 && st_out.slot_cnt == st_out.my_slot) else $error("beacon start off slot edge"); // R17
	a_tx_airtime: assert property ($fell(st_out.tx_on) |-> $past(s_r.txc) == BCN_LAST) else $error("beacon airtime wrong"); // R17
	a_tx_in_bp: assert property (st_out.tx_start |-> st_out.my_slot >= SIG_SLOTS && st_out.my_slot < MAX_BP) else $error("beacon slot outside period"); // R18
	a_ready_gate: assert property (st_out.bcn_ready |-> $past(cfg.peer_found) && ($past(cfg.dev_b) || !$past(cfg.peer_trains) || $past(cfg.train_done))) else $error("ready without peer"); // R1
	a_create_slot: assert property ($rose(st_out.active) && st_out.created |-> st_out.my_slot == SIG_SLOTS) else $error("new period slot wrong"); // R4
	a_scan_len: assert property ($rose(st_out.active) |-> $past(s_r.ok_seen) || $past(s_r.scan_sf) >= SCAN_MIN) else $error("scan too short"); // R2
	a_extra_scan: assert property (s_r.st == ST_SCAN && s_r.hdr_seen && !s_r.ok_seen && s_r.scan_sf < SCAN_NOBCN && sf_end && !(rx.preempt && cfg.disc_chan) |=> s_r.st == ST_SCAN) else $error("extra scan skipped"); // R3
	a_no_earlier: assert property (s_r.st == ST_BEACON && $past(s_r.st) == ST_BEACON && $changed(st_out.my_slot) |-> st_out.my_slot >= $past(hi_unav)) else $error("beacon moved too early"); // R9
	a_lock_hold: assert property (s_r.o.lock && $past(s_r.o.lock) && $past(s_r.st) == ST_BEACON |-> $stable(st_out.my_slot)) else $error("locked slot moved"); // R14
	a_bplen_cap: assert property (st_out.bp_len <= MAX_BP) else $error("announced length over limit"); // R22
	a_preempt_susp: assert property (rx.preempt && cfg.disc_chan && s_r.st == ST_BEACON |=> st_out.suspended ##1 !st_out.tx_start) else $error("preemption ignored"); // R15
	a_quiet_nbr: assert property (st_out.quiet |-> !st_out.tx_start) else $error("sent in neighbour period"); // R8
	a_withhold_b: assert property (st_out.withheld |-> !st_out.active && !st_out.bcn_ready) else $error("withheld yet beaconing"); // R13
	a_absence: assert property (st_out.active && st_out.absence_req && s_r.lat >= DISC_LAT |=> st_out.disc_late) else $error("late absence not flagged"); // R10

	c_create: cover property ($rose(st_out.active) && st_out.created);
	c_join: cover property ($rose(st_out.active) && !st_out.created);
	c_relocate: cover property (st_out.relocate);
	c_suspend: cover property ($rose(st_out.suspended));
endmodule
`default_nettype wire

// >>> verification/bps_peer.sv
// Peer station model: one aligned beacon per superframe in a chosen slot
`timescale 1ns/10ps
`default_nettype none
module bps_peer
(
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// Shared superframe start and beacon setup
	input  wire logic               bp_start,
	input  wire logic               en,
	input  wire logic               preempt,
	input  wire bps_pkg::bps_slot_t bcn_slot,
	input  wire bps_pkg::bps_slot_t bcn_len,
	// Receive events seen by the device
	output var  bps_pkg::bps_rx_t   rx
);
	import bps_pkg::*;

	int   cyc;
	int   slot;
	logic synced;
	logic hit;

	assign hit = synced && en && (slot == int'(bcn_slot)) && (cyc == 10);

	// Slot timing follows the shared period start
	always @(negedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			synced <= 1'b0;
			cyc    <= 0;
			slot   <= 0;
		end
		else if (bp_start)
		begin
			synced <= 1'b1;
			cyc    <= 0;
			slot   <= 0;
		end
		else if (synced)
		begin
			cyc  <= (cyc == SLOT_CYC - 1) ? 0 : cyc + 1;
			slot <= (cyc == SLOT_CYC - 1) ? slot + 1 : slot;
		end
	end

	// Fields slot_num, bp_len, occ_slot and occ_bcst keep changing when not qualified by a pulse
	always @(negedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx <= '0;
		else
		begin
			rx.hdr        <= hit;
			rx.fcs_ok     <= hit;
			rx.aligned    <= hit;
			rx.type_b     <= 1'b0;
			rx.preempt    <= hit && preempt;
			rx.sig_slot   <= 1'b0;
			rx.busy_other <= 1'b0;
			rx.occ_vld    <= 1'b0;
			rx.occ_bcst   <= ~rx.occ_bcst;
			rx.slot_num   <= hit ? bcn_slot : ~rx.slot_num;
			rx.bp_len     <= hit ? bcn_len : ~rx.bp_len;
			rx.occ_slot   <= ~rx.occ_slot;
		end
	end
endmodule
`default_nettype wire

// >>> verification/bps_mgr_tb.sv
// Self-checking bench: Type A scan, join, beacon timing, period length, preemption
`timescale 1ns/10ps
`default_nettype none
module bps_mgr_tb;
	import bps_pkg::*;

	logic      ref_clk;
	logic      rst_n;
	bps_cfg_t  cfg;
	bps_rx_t   rx;
	bps_out_t  st_out;
	int        err_count;
	int        total_checks;
	int        n;
	logic      peer_pre;

	bps_mgr bps_mgr_inst
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.cfg     (cfg),
		.rx      (rx),
		.st_out  (st_out)
	);

	bps_peer bps_peer_inst
	(
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.bp_start (st_out.bp_start),
		.en       (1'b1),
		.preempt  (peer_pre),
		.bcn_slot (8'h05),
		.bcn_len  (8'h08),
		.rx       (rx)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Kind 0 period start, 1 own beacon start, else slot number s
	task automatic wait_ev(input int kind, input bps_slot_t s, input int limit, output int cnt);
		logic hit;
		cnt = 0;
		hit = 1'b0;
		while (!hit)
		begin
			@(negedge ref_clk);
			cnt++;
			case (kind)
				0: hit = (st_out.bp_start === 1'b1);
				1: hit = (st_out.tx_start === 1'b1);
				default: hit = (st_out.slot_cnt === s);
			endcase
			if (cnt > limit)
			begin
				err_count++;
				$display("BAD t=%0t seen=%h exp=%h", $time, cnt, limit);
				finish_test();
			end
		end
	endtask

	task automatic t_disc();
		repeat (2) @(negedge ref_clk);
		check(st_out.sf_ex_en, 1);
		cfg.disc_chan = 1'b1;
		cfg.disc_busy = 1'b1;
		repeat (3) @(negedge ref_clk);
		check(st_out.sf_ex_en, 0);
		cfg.disc_chan = 1'b0;
		cfg.disc_busy = 1'b0;
		repeat (3) @(negedge ref_clk);
		check(st_out.sf_ex_en, 1);
	endtask

	task automatic t_scan_join();
		wait_ev(0, 8'h00, 26000, n);
		check(st_out.slot_cnt, 0);
		cfg.power_save = 1'b1;
		wait_ev(0, 8'h00, 26000, n);
		cfg.power_save = 1'b0;
		check(n, 25600);
		check(st_out.bp_len, 8'h06);
		check(st_out.dual, 0);
		check(st_out.relocate, 0);
		check(st_out.lock, 0);
		check(st_out.disc_late, 0);
		check(st_out.suspended, 0);
		check(st_out.active, 1);
		check(st_out.created, 0);
		check(st_out.withheld, 0);
		check(st_out.my_slot, 8'h06);
		check(st_out.bcn_ready, 0);
	endtask

	task automatic t_tx();
		int k;
		wait_ev(2, 8'h03, 400, n);
		check(st_out.quiet, 1);
		wait_ev(1, 8'h00, 400, k);
		check(n + k, 600);
		check(st_out.slot_cnt, st_out.my_slot);
		check(st_out.quiet, 0);
		k = 0;
		while (st_out.tx_on === 1'b1 && k < 200)
		begin
			k++;
			@(negedge ref_clk);
		end
		check(k, BCN_CYC);
		wait_ev(2, 8'h14, 2000, n);
		check(st_out.quiet, 0);
	endtask

	task automatic t_ready_abs();
		cfg.train_done = 1'b1;
		repeat (3) @(negedge ref_clk);
		check(st_out.bcn_ready, 1);
		check(st_out.absence_req, 1);
		cfg.abs_grant = 1'b1;
		@(negedge ref_clk);
		cfg.abs_grant = 1'b0;
		repeat (3) @(negedge ref_clk);
		check(st_out.absence_req, 0);
	endtask

	task automatic t_move();
		bps_slot_t bad[3];
		bad = '{8'h03, 8'h28, 8'h01};
		foreach (bad[i])
		begin
			cfg.move_req  = 1'b1;
			cfg.move_slot = bad[i];
			@(negedge ref_clk);
			cfg.move_req  = 1'b0;
			repeat (3) @(negedge ref_clk);
			check(st_out.my_slot, 8'h06);
		end
	endtask

	task automatic t_bplen();
		wait_ev(0, 8'h00, 26000, n);
		repeat (2) @(negedge ref_clk);
		check(st_out.bp_len, 8'h0B);
	endtask

	// Preemptive beacon on the discovery channel suspends beaconing
	task automatic t_preempt();
		cfg.disc_chan = 1'b1;
		peer_pre      = 1'b1;
		wait_ev(2, 8'h06, 700, n);
		check(st_out.suspended, 1);
		check(st_out.active, 0);
		check(st_out.tx_start, 0);
		check(st_out.sf_ex_en, 1);
	endtask

	initial
	begin
		err_count    = 0;
		total_checks = 0;
		cfg          = '0;
		cfg.start_scan  = 1'b1;
		cfg.peer_found  = 1'b1;
		cfg.peer_trains = 1'b1;
		peer_pre = 1'b0;
		rst_n = 1'b0;
		repeat (16) @(negedge ref_clk);
		check(st_out, '0);
		rst_n = 1'b1;
		t_disc();
		t_scan_join();
		t_tx();
		t_ready_abs();
		t_move();
		t_bplen();
		t_preempt();
		finish_test();
	end

	// Overall hang limit
	initial
	begin
		#950000;
		err_count++;
		finish_test();
	end
endmodule
`default_nettype wire
